// >>> inc/dtpg_pkg.sv
// package with register map, field layout and timing constants of the timers
// Notes on behaviour
// [RULE1] timer a 16 bits, all zero at reset
// [RULE2] five clocks, slow default, fast needs enables
// [RULE3] optional divide by ten for on counter
// [RULE4] run start: interrupt, load both counters
// [RULE5] zero toggles phase, alternate shadow reloads
// [RULE6] out a high in high phase, b inverse
// [RULE7] clock mode outputs half clock in high
// [RULE8] cycle end: interrupt, reload counters, shadows
// [RULE9] new reloads reach shadows at cycle end
// [RULE10] interrupt also raised at timer start
// [RULE11] disabled timer reset, reload registers kept
// [RULE12] reads return live counters, not registers
// [RULE13] freeze bit stops counting until cleared
// [RULE14] timer b 14 bits, divided system clock
// [RULE15] period counter reloads, sets outputs high
// [RULE16] duty counter compares, cleared at zero period
// [RULE17] three outputs, duty zero to full
// [RULE18] software keeps duty not above period
// [RULE19] radio activity freezes duty, forces low
// [RULE20] clearing auto pause keeps duty constant
// [RULE21] reloads and compares on terminal edge
package dtpg_pkg;
  localparam int unsigned TA_W = 16;
  localparam int unsigned TB_W = 14;
  localparam int unsigned DIV10_N = 10;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ON = 8'h04;
  localparam logic [7:0] A_HIGH = 8'h08;
  localparam logic [7:0] A_LOW = 8'h0c;
  localparam logic [7:0] A_FRZ_SET = 8'h10;
  localparam logic [7:0] A_FRZ_CLR = 8'h14;
  localparam logic [7:0] A_CLK = 8'h18;
  localparam logic [7:0] A_B_CTRL = 8'h1c;
  localparam logic [7:0] A_B_PER = 8'h20;
  localparam logic [7:0] A_B_DUTY0 = 8'h24;
  localparam logic [7:0] A_STAT = 8'h30;
  // timer a control bits
  localparam int unsigned C_RUN = 0;
  localparam int unsigned C_FAST = 1;
  localparam int unsigned C_DIV10 = 2;
  localparam int unsigned C_CLKMODE = 3;
  // clock register bits
  localparam int unsigned K_EN = 0;
  localparam int unsigned K_DIV = 1;
  // timer b control bits
  localparam int unsigned B_EN = 0;
  localparam int unsigned B_HWP = 1;
  localparam int unsigned B_SWP = 2;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // last member is bit zero, so run sits at bit C_RUN
  typedef struct packed {
    logic clkmode;
    logic div10;
    logic fast;
    logic run;
  } dtpg_actrl_t;
endpackage : dtpg_pkg

// >>> src/dtpg_top.sv
// timer pair with axi4-lite register slave
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dtpg_top #(
  parameter int unsigned SLOW_DIV = 500
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        radio_tx_active,
  input  wire logic        radio_rx_active,
  output var  logic        wave_out_a,
  output var  logic        wave_out_a_inverted,
  output var  logic        timer_a_interrupt,
  output var  logic        wave_out_b0,
  output var  logic        wave_out_b1,
  output var  logic        wave_out_b2
);
  localparam int unsigned AW = dtpg_pkg::TA_W;
  localparam int unsigned BW = dtpg_pkg::TB_W;

  // register state
  dtpg_pkg::dtpg_actrl_t ctrl_q;
  logic [AW-1:0] on_reload_q, high_reload_q, low_reload_q;
  logic          freeze_q;
  logic [2:0]    clk_q;        // enable, divider select
  logic [2:0]    bctrl_q;
  logic [BW-1:0] period_q;
  logic [BW-1:0] duty_q [3];

  // axi handshake state
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // bus write capture; address and data taken in either order
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire [7:0] wa = awaddr_q;
  wire rd_take = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) aw_hold_q <= 1'b0;
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) w_hold_q <= 1'b0;
    end
  end

  // address decode of the held write, answered with okay or error
  wire wr_hit = (wa == dtpg_pkg::A_CTRL) | (wa == dtpg_pkg::A_ON)
              | (wa == dtpg_pkg::A_HIGH) | (wa == dtpg_pkg::A_LOW)
              | (wa == dtpg_pkg::A_FRZ_SET) | (wa == dtpg_pkg::A_FRZ_CLR)
              | (wa == dtpg_pkg::A_CLK) | (wa == dtpg_pkg::A_B_CTRL)
              | (wa == dtpg_pkg::A_B_PER) | (wa == dtpg_pkg::A_B_DUTY0)
              | (wa == dtpg_pkg::A_B_DUTY0 + 8'h04)
              | (wa == dtpg_pkg::A_B_DUTY0 + 8'h08);

  // ready while the holding slot is free and no write response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= dtpg_pkg::RESP_OK;
    end else begin
      s_axi_awready <= ~aw_hold_q & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_hold_q & ~w_take & ~s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? dtpg_pkg::RESP_OK : dtpg_pkg::RESP_ERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // byte lanes masked by the strobes taken with the data
  wire [31:0] wd = wdata_q & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                              {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // software registers; reload registers survive a stopped timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q        <= '0;
      on_reload_q   <= '0;  // RULE1
      high_reload_q <= '0;
      low_reload_q  <= '0;
      freeze_q      <= 1'b0;
      clk_q         <= 3'h0;
      bctrl_q       <= 3'h4;
      period_q      <= '0;
    end else if (wr_go) begin
      unique case (wa)
        dtpg_pkg::A_CTRL:    ctrl_q <= wd[3:0];
        dtpg_pkg::A_ON:      on_reload_q <= wd[AW-1:0];
        dtpg_pkg::A_HIGH:    high_reload_q <= wd[AW-1:0];
        dtpg_pkg::A_LOW:     low_reload_q <= wd[AW-1:0];
        dtpg_pkg::A_FRZ_SET: if (wd[0]) freeze_q <= 1'b1;  // RULE13
        dtpg_pkg::A_FRZ_CLR: if (wd[0]) freeze_q <= 1'b0;  // RULE13
        dtpg_pkg::A_CLK:     clk_q <= wd[2:0];
        dtpg_pkg::A_B_CTRL:  bctrl_q <= wd[2:0];
        dtpg_pkg::A_B_PER:   period_q <= wd[BW-1:0];
        default: ;
      endcase
    end
  end

  // duty registers, one per timer b output
  for (genvar i = 0; i < 3; i++) begin : g_duty
    localparam logic [7:0] OFS = dtpg_pkg::A_B_DUTY0 + 8'(4*i);
    always_ff @(posedge aclk) begin
      if (!aresetn) duty_q[i] <= '0;
      else if (wr_go && wa == OFS) duty_q[i] <= wd[BW-1:0];
    end
  end

  // timer a clock tick: fast divided clock or slow tick every SLOW_DIV clocks
  logic [8:0]  pre_q;
  logic [15:0] slow_q;
  logic [3:0]  d10_q;
  wire fast_on = ctrl_q.fast & clk_q[dtpg_pkg::K_EN];  // RULE2
  wire [1:0] dsel = clk_q[2:1];
  // 200 MHz scaled to 16/8/4/2 MHz equivalents by prescale of 12.5 -> 12
  wire fast_tick = (pre_q[3:0] == 4'hb) &
                   (dsel == 2'h0 | (dsel == 2'h1 & pre_q[4])
                  | (dsel == 2'h2 & pre_q[5:4] == 2'h3)
                  | (dsel == 2'h3 & pre_q[6:4] == 3'h7));
  wire slow_tick = (slow_q == 16'(SLOW_DIV - 1));
  wire a_tick = fast_on ? fast_tick : slow_tick;  // RULE2
  wire run = ctrl_q.run;
  wire step = a_tick & ~freeze_q;  // RULE13
  wire on_step = step & (~ctrl_q.div10 | d10_q == 4'(dtpg_pkg::DIV10_N-1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q  <= '0;
      slow_q <= '0;
    end else begin
      pre_q  <= (pre_q[3:0] == 4'hb) ? {pre_q[8:4] + 5'h1, 4'h0}
                                     : pre_q + 9'h1;
      slow_q <= slow_tick ? 16'h0 : slow_q + 16'h1;
    end
  end

  // timer a counters and phase
  logic [AW-1:0] main_q, on_q, sh_high_q, sh_low_q;
  logic          phase_q, started_q, irq_q, half_q;
  wire main_zero = (main_q == '0);
  wire on_zero   = (on_q == '0);
  wire cycle_end = main_zero & on_zero & ~phase_q;  // RULE8

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin  // RULE11
      main_q <= '0; on_q <= '0; sh_high_q <= '0; sh_low_q <= '0;
      phase_q <= 1'b0; started_q <= 1'b0; irq_q <= 1'b0;
      d10_q <= '0; half_q <= 1'b0;
    end else begin
      irq_q <= 1'b0;
      if (step) half_q <= ~half_q;  // RULE7
      if (step && ctrl_q.div10)
        d10_q <= (d10_q == 4'(dtpg_pkg::DIV10_N-1)) ? 4'h0 : d10_q + 4'h1;  // RULE3
      if (!started_q || (step && cycle_end)) begin
        started_q <= 1'b1;
        irq_q     <= 1'b1;  // RULE4 RULE10
        main_q    <= high_reload_q;
        sh_high_q <= high_reload_q;  // RULE9
        sh_low_q  <= low_reload_q;
        on_q      <= on_reload_q;
        phase_q   <= 1'b1;
      end else if (step) begin
        if (main_zero) begin
          phase_q <= ~phase_q;  // RULE5 RULE21
          main_q  <= phase_q ? sh_low_q : sh_high_q;
        end else main_q <= main_q - 16'h1;
        if (on_step && !on_zero) on_q <= on_q - 16'h1;
      end
    end
  end

  // timer a outputs from flops
  wire a_level = phase_q & (~ctrl_q.clkmode | half_q);  // RULE6 RULE7
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_out_a          <= 1'b0;
      wave_out_a_inverted <= 1'b1;
      timer_a_interrupt   <= 1'b0;
    end else begin
      wave_out_a          <= a_level;
      wave_out_a_inverted <= ~a_level;  // RULE6
      timer_a_interrupt   <= irq_q;
    end
  end

  // timer b: system clock divided by 1, 2, 4 or 8
  logic [2:0]    bdiv_q;
  logic [BW-1:0] pcnt_q, dcnt_q;
  logic [2:0]    bout_q;
  wire b_en  = bctrl_q[dtpg_pkg::B_EN];  // RULE14
  wire b_tick = (dsel == 2'h0) | (dsel == 2'h1 & bdiv_q[0])
              | (dsel == 2'h2 & bdiv_q[1:0] == 2'h3)
              | (dsel == 2'h3 & bdiv_q == 3'h7);
  wire pause = bctrl_q[dtpg_pkg::B_HWP] & bctrl_q[dtpg_pkg::B_SWP]
             & (radio_tx_active | radio_rx_active);  // RULE19 RULE20
  wire p_zero = (pcnt_q == '0);

  always_ff @(posedge aclk) begin
    if (!aresetn || !b_en) begin
      bdiv_q <= '0; pcnt_q <= '0; dcnt_q <= '0; bout_q <= '0;
    end else begin
      bdiv_q <= bdiv_q + 3'h1;
      if (b_tick) begin
        pcnt_q <= p_zero ? period_q : pcnt_q - 14'h1;  // RULE15 RULE21
        if (period_q == '0) dcnt_q <= '0;  // RULE16
        else if (p_zero) dcnt_q <= '0;
        else if (!pause) dcnt_q <= dcnt_q + 14'h1;  // RULE19
        for (int i = 0; i < 3; i++) begin
          if (p_zero) bout_q[i] <= (duty_q[i] != '0);  // RULE15 RULE17
          else if (!pause && duty_q[i] != period_q  // full duty never falls
                   && dcnt_q + 14'h1 == duty_q[i])
            bout_q[i] <= 1'b0;  // RULE16 RULE18
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_out_b0 <= 1'b0; wave_out_b1 <= 1'b0; wave_out_b2 <= 1'b0;
    end else begin
      wave_out_b0 <= bout_q[0] & ~pause;  // RULE19
      wave_out_b1 <= bout_q[1] & ~pause;
      wave_out_b2 <= bout_q[2] & ~pause;
    end
  end

  // read path returns live counters at reload addresses
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0;
    unique case (s_axi_araddr)
      dtpg_pkg::A_CTRL:   rmux = {28'h0, ctrl_q};
      dtpg_pkg::A_ON:     rmux = {16'h0, on_q};  // RULE12
      dtpg_pkg::A_HIGH,
      dtpg_pkg::A_LOW:    rmux = {16'h0, main_q};  // RULE12
      dtpg_pkg::A_CLK:    rmux = {29'h0, clk_q};
      dtpg_pkg::A_B_CTRL: rmux = {29'h0, bctrl_q};
      dtpg_pkg::A_B_PER:  rmux = {18'h0, period_q};
      dtpg_pkg::A_B_DUTY0: rmux = {18'h0, duty_q[0]};
      dtpg_pkg::A_STAT:   rmux = {26'h0, freeze_q, pause, phase_q,
                                  bout_q};
      default: rmux = 32'h0;
    endcase
  end
  wire rd_hit = (s_axi_araddr <= dtpg_pkg::A_STAT)
              & (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= dtpg_pkg::RESP_OK;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rmux;
        s_axi_rresp  <= rd_hit ? dtpg_pkg::RESP_OK : dtpg_pkg::RESP_ERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  chk_inverse_pair: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 wave_out_a_inverted == ~wave_out_a) else $error("pair not inverse"); // RULE6
  chk_start_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(run) |-> ##2 timer_a_interrupt) else $error("no start irq"); // RULE10
  chk_freeze_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    freeze_q && started_q && run |=> $stable(main_q))
    else $error("frozen counter moved"); // RULE13
  chk_stop_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    !run |=> main_q == '0 && on_q == '0) else $error("stop not clear"); // RULE11
  chk_pause_low: assert property (@(posedge aclk) disable iff (!aresetn)
    pause |=> !wave_out_b0 && !wave_out_b1) else $error("pause not low"); // RULE19
  chk_zero_period: assert property (@(posedge aclk) disable iff (!aresetn)
    b_en && period_q == '0 && b_tick |=> dcnt_q == '0)
    else $error("duty counter not clear"); // RULE16
  chk_phase_flip: assert property (@(posedge aclk) disable iff (!aresetn)
    step && started_q && main_zero && !cycle_end && run
    |=> phase_q != $past(phase_q)) else $error("phase stuck"); // RULE5
  chk_b_disable: assert property (@(posedge aclk) disable iff (!aresetn)
    !b_en |=> ##1 !wave_out_b2) else $error("b out while off"); // RULE14
endmodule : dtpg_top
`default_nettype wire

// >>> bench/dtpg_bench.sv
// self-checking bench for the timer pair, driven over its register bus
`timescale 1ns/1ps
`default_nettype none
module dtpg_bench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tx, rx;
  logic        v;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd, rd2;
  logic [1:0]  rs;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [5:0]  wv;
  int          n_fail, total_checks, n_irq, hi, per, k, e;

  // slow tick shortened so a timer cycle lasts tens of clocks
  dtpg_top #(.SLOW_DIV(4)) u_dtpg_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .radio_tx_active(tx), .radio_rx_active(rx),
    .wave_out_a(wv[0]), .wave_out_a_inverted(wv[1]),
    .timer_a_interrupt(wv[2]), .wave_out_b0(wv[3]),
    .wave_out_b1(wv[4]), .wave_out_b2(wv[5]));

  // 200 mhz clock
  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;

  // counts interrupt pulses as they appear
  always @(posedge aclk)
    if (wv[2] === 1'b1) n_irq <= n_irq + 1;

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic tmo();
    n_fail++;
    $display("BAD %0t wait expired got 0 exp 1", $time);
    close_out();
  endtask : tmo

  task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask : chk_word

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] x);
    total_checks++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %0t resp got %h exp %h", $time, g, x);
    end
  endtask : chk_resp

  // one write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic dn;
    int   j;
    dn = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (j = 0; j < 200 && !dn; j++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        dn = 1'b1;
        bready <= 1'b0;
        chk_resp(bresp, dtpg_pkg::RESP_OK);
      end
    end
    if (!dn) tmo();
  endtask : wr

  // one read; data compared when an okay answer is expected and cd is set
  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                     input logic [1:0] xr, input logic cd = 1'b1);
    logic dn;
    int   j;
    dn = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (j = 0; j < 200 && !dn; j++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        dn = 1'b1;
        rready <= 1'b0;
        rd = rdata;
        chk_resp(rresp, xr);
        if (xr == dtpg_pkg::RESP_OK && cd) chk_word(rdata, x);
      end
    end
    if (!dn) tmo();
  endtask : rdc

  // high time and full period of one output, in clocks
  task automatic meas(input int i, output int h, output int p);
    int j;
    for (j = 0; j < 4000 && wv[i]; j++) @(posedge aclk);
    for (j = 0; j < 4000 && !wv[i]; j++) @(posedge aclk);
    for (j = 0; j < 4000 && wv[i]; j++) @(posedge aclk);
    h = j;
    for (j = 0; j < 4000 && !wv[i]; j++) @(posedge aclk);
    p = h + j;
    if (j == 4000 || h == 4000) tmo();
  endtask : meas

  // output must keep one level for n clocks
  task automatic hold(input int i, input logic lv, input int n);
    int j, b;
    b = 0;
    for (j = 0; j < n; j++) begin
      @(posedge aclk);
      if (wv[i] !== lv) b++;
    end
    chk_word(b, 0);
  endtask : hold

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tx, rx} = '0;
    {awaddr, araddr, wdata} = '0;
    {n_fail, total_checks, n_irq} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk_word(wv, 32'h2);
    rdc(dtpg_pkg::A_CTRL, 0, dtpg_pkg::RESP_OK);
    rdc(dtpg_pkg::A_ON, 0, dtpg_pkg::RESP_OK);
    rdc(dtpg_pkg::A_HIGH, 0, dtpg_pkg::RESP_OK);
    rdc(dtpg_pkg::A_LOW, 0, dtpg_pkg::RESP_OK);
    rdc(dtpg_pkg::A_B_CTRL, 32'h4, dtpg_pkg::RESP_OK);
    rdc(8'h40, 0, dtpg_pkg::RESP_ERR);
    $display("test reset done");
    // timer a: high 3, low 5, on 2
    wr(dtpg_pkg::A_HIGH, 32'h3);
    wr(dtpg_pkg::A_LOW, 32'h5);
    wr(dtpg_pkg::A_ON, 32'h2);
    wr(dtpg_pkg::A_CTRL, 32'h1);
    repeat (8) @(posedge aclk);
    chk_word(n_irq, 1);
    meas(0, hi, per);
    chk_word(hi * 6, (per - hi) * 4);
    meas(2, hi, k);
    chk_word(k, per);
    e = 0;
    for (k = 0; k < 60; k++) begin
      @(posedge aclk);
      if (wv[1] !== ~wv[0]) e++;
    end
    chk_word(e, 0);
    $display("test timer a run done");
    wr(dtpg_pkg::A_FRZ_SET, 32'h1);
    rdc(dtpg_pkg::A_HIGH, 0, dtpg_pkg::RESP_OK, 1'b0);
    rd2 = rd;
    v = wv[0];
    hold(0, v, 40);
    rdc(dtpg_pkg::A_HIGH, rd2, dtpg_pkg::RESP_OK);
    wr(dtpg_pkg::A_FRZ_CLR, 32'h1);
    meas(0, hi, k);
    chk_word(k, per);
    $display("test freeze done");
    wr(dtpg_pkg::A_HIGH, 32'h7);
    meas(0, hi, per);
    chk_word(hi * 6, (per - hi) * 8);
    wr(dtpg_pkg::A_CTRL, 32'h9);
    e = 0;
    v = wv[0];
    for (k = 0; k < 2 * per; k++) begin
      @(posedge aclk);
      if (wv[0] && !v) e++;
      v = wv[0];
    end
    chk_word(e > 4, 1);
    wr(dtpg_pkg::A_CTRL, 32'h0);
    repeat (4) @(posedge aclk);
    chk_word(wv[1:0], 32'h2);
    rdc(dtpg_pkg::A_HIGH, 0, dtpg_pkg::RESP_OK);
    rdc(dtpg_pkg::A_ON, 0, dtpg_pkg::RESP_OK);
    wr(dtpg_pkg::A_CLK, 32'h1);
    wr(dtpg_pkg::A_CTRL, 32'h7);
    repeat (60) @(posedge aclk);
    rdc(dtpg_pkg::A_ON, 32'h2, dtpg_pkg::RESP_OK);
    meas(0, hi, per);
    chk_word(hi * 6, (per - hi) * 8);
    chk_word(per, 168);
    wr(dtpg_pkg::A_CTRL, 32'h0);
    $display("test timer a modes done");
    // timer b: enabled at period 0, then period 9, duties 0, 4 and 9
    wr(dtpg_pkg::A_B_CTRL, 32'h5);
    hold(4, 1'b0, 10);
    wr(dtpg_pkg::A_B_PER, 32'h9);
    wr(dtpg_pkg::A_B_DUTY0, 32'h0);
    wr(dtpg_pkg::A_B_DUTY0 + 8'h04, 32'h4);
    wr(dtpg_pkg::A_B_DUTY0 + 8'h08, 32'h9);
    meas(4, hi, per);
    chk_word(per, 10);
    chk_word(hi, 4);
    hold(3, 1'b0, 30);
    hold(5, 1'b1, 30);
    wr(dtpg_pkg::A_CLK, 32'h3);
    meas(4, hi, per);
    chk_word(per, 20);
    wr(dtpg_pkg::A_CLK, 32'h1);
    $display("test timer b done");
    wr(dtpg_pkg::A_B_CTRL, 32'h7);
    tx <= 1'b1;
    repeat (3) @(posedge aclk);
    hold(5, 1'b0, 30);
    tx <= 1'b0;
    rx <= 1'b1;
    hold(5, 1'b0, 20);
    rx <= 1'b0;
    repeat (12) @(posedge aclk);
    hold(5, 1'b1, 10);
    wr(dtpg_pkg::A_B_CTRL, 32'h3);
    tx <= 1'b1;
    hold(5, 1'b1, 30);
    tx <= 1'b0;
    $display("test radio pause done");
    close_out();
  end
endmodule : dtpg_bench
`default_nettype wire
